// ---- src/piu_defs.vh ----
// Constants for the priority interrupt unit: register map, option fields, vectors, states.
`ifndef PIU_DEFS_VH
`define PIU_DEFS_VH
`define PIU_ADDR_W 8
`define PIU_OFS_CONFIG 8'hC8
`define PIU_OFS_STATUS 8'hC0
`define PIU_OFS_PEND 8'hC1
`define PIU_OFS_SRCFLAG 8'hC2
`define PIU_CONFIG_RST 8'h00
`define PIU_CONFIG_MASK 8'h70
`define PIU_BIT_GEN 4
`define PIU_BIT_ESB 5
`define PIU_BIT_LES 6
`define PIU_VEC_SRC0 12'hFFC
`define PIU_VEC_SRC1 12'hFF6
`define PIU_VEC_SRC2 12'hFF4
`define PIU_VEC_SRC3 12'hFF2
`define PIU_VEC_SRC4 12'hFF0
`define PIU_MODE_NORMAL 2'h0
`define PIU_MODE_IRQ 2'h1
`define PIU_MODE_NMI 2'h2
`define PIU_ST_NORMAL 3'h1
`define PIU_ST_IRQ 3'h2
`define PIU_ST_NMI 3'h4
`define PIU_QUIRK_CYCLES 2'h3
`define PIU_ZERO8 8'h00
`define PIU_ZERO12 12'h000
`endif

// ---- src/piu_top.v ----
// Priority interrupt unit: request capture, priority, entry and return sequencing.
// Summary of operation
// - Non-maskable request outranks all and preempts a maskable routine, not its own; maskable ones never nest.
// - Pending maskable requests are served in fixed order, source one first.
// - Each source selects its own vector; the vector is loaded on acceptance.
// - Global enable gates all maskable sources; non-maskable stays active.
// - With global enable cleared, no source may wake the core.
// - Non-maskable request is held in a flip-flop, cleared when its routine starts.
// - Source one is level sensitive when option bit 6 set, else falling edge.
// - Source two is edge sensitive; option bit 5 set means rising edge.
// - Sources three and four are high-level sensitive, sampled at instruction end.
// - An edge latch holds one request until its routine starts; extra edges lost.
// - Requests are checked at instruction end; accepted one replaces next instruction.
// - Entry swaps flags, pushes PC, inhibits maskable lines, clears latch, loads vector.
// - Three flag sets, normal, interrupt and non-maskable, switch automatically.
// - Return restores the previous flag set and pops the saved PC.
// - Maskable entry during first 3 cycles of option clear keeps normal flags.
// - Option register at C8h is write-only, resets to 00h, unused bits ignored.
// - Each ORed event sets its own pollable flag.
// - Timer to vector 3, converter to 4, port A to 1, port B to 2.
// - Wait or stop is refused while an enabled request is pending.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "piu_defs.vh"
module piu_top (
	input wire mclk_i,
	input wire rst_n_i,
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	input wire nmi_n_i,
	input wire [7:0] porta_irq_n_i,
	input wire [7:0] portb_irq_n_i,
	input wire timer_zero_flag_i,
	input wire timer_irq_enable_i,
	input wire adc_eoc_i,
	input wire adc_irq_enable_i,
	input wire instr_end_i,
	input wire option_clear_window_i,
	input wire return_from_interrupt_i,
	input wire [11:0] pc_i,
	input wire carry_i,
	input wire zero_i,
	input wire flags_we_i,
	input wire low_power_req_i,
	input wire low_power_i,
	output reg accept_o,
	output reg [11:0] vector_o,
	output reg pc_load_o,
	output reg [11:0] ret_pc_o,
	output reg ret_o,
	output reg carry_o,
	output reg zero_o,
	output reg [1:0] mode_o,
	output reg low_power_grant_o,
	output reg wake_o
);
	// Pins pass two flip-flops before any logic reads them.
	reg [17:0] meta_q;
	reg [17:0] sync_q;
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 18'h3FFFF;
			sync_q <= 18'h3FFFF;
		end else begin
			meta_q <= {nmi_n_i, porta_irq_n_i, portb_irq_n_i, 1'b1};
			sync_q <= meta_q;
		end
	end
	wire nmi_n_s = sync_q[17];
	wire [7:0] pa_n_s = sync_q[16:9];
	wire [7:0] pb_n_s = sync_q[8:1];
	reg [17:0] prev_q;
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			prev_q <= 18'h3FFFF;
		else
			prev_q <= sync_q;
	end

	reg [7:0] config_q;
	wire gen = config_q[`PIU_BIT_GEN];
	wire src1_level_select = config_q[`PIU_BIT_LES];
	wire src2_edge_polarity = config_q[`PIU_BIT_ESB];

	// Per-pin event flags for polling, one generate loop over the port bits.
	reg [7:0] pa_flag_q;
	reg [7:0] pb_flag_q;
	reg [7:0] flag_clr_a;
	reg [7:0] flag_clr_b;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
			wire a_ev = src1_level_select ? ~pa_n_s[gi] : (prev_q[9 + gi] & ~pa_n_s[gi]);
			wire b_ev = src2_edge_polarity ? (~prev_q[1 + gi] & pb_n_s[gi]) : (prev_q[1 + gi] & ~pb_n_s[gi]);
			always @(posedge mclk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					pa_flag_q[gi] <= 1'b0;
					pb_flag_q[gi] <= 1'b0;
				end else begin
					pa_flag_q[gi] <= a_ev | (pa_flag_q[gi] & ~flag_clr_a[gi]);
					pb_flag_q[gi] <= b_ev | (pb_flag_q[gi] & ~flag_clr_b[gi]);
				end
			end
		end
	endgenerate

	wire nmi_edge = prev_q[17] & ~nmi_n_s;
	wire src1_edge = |(prev_q[16:9] & ~pa_n_s);
	wire src2_edge = src2_edge_polarity ? |(~prev_q[8:1] & pb_n_s) : |(prev_q[8:1] & ~pb_n_s);
	wire src1_level = |(~pa_n_s);
	// Sources three and four are not stored: they count only while they are held.
	wire src3_req = timer_zero_flag_i & timer_irq_enable_i;
	wire src4_req = adc_eoc_i & adc_irq_enable_i;

	reg nmi_q;
	reg src1_lat_q;
	reg src2_lat_q;
	localparam [2:0] ST_NORMAL = `PIU_ST_NORMAL;
	localparam [2:0] ST_IRQ = `PIU_ST_IRQ;
	localparam [2:0] ST_NMI = `PIU_ST_NMI;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [1:0] mode_q;
	reg [1:0] mode_d;
	reg [11:0] stack_q;
	reg stack_mode_irq_q;
	reg [5:0] flags_q;
	reg quirk_q;

	wire src1_req = src1_level_select ? src1_level : src1_lat_q;
	wire mask_ok = gen & (mode_q == `PIU_MODE_NORMAL);
	wire take_nmi = nmi_q & (mode_q != `PIU_MODE_NMI);
	wire [4:1] mreq = {src4_req, src3_req, src2_lat_q, src1_req};
	wire any_m = mask_ok & (|mreq);
	wire take = instr_end_i & (take_nmi | any_m);

	reg [11:0] vec;
	reg [2:0] sel;
	always @* begin
		vec = `PIU_ZERO12;
		sel = 3'd0;
		if (take_nmi) begin
			vec = `PIU_VEC_SRC0;
			sel = 3'd0;
		end else if (mreq[1]) begin
			vec = `PIU_VEC_SRC1;
			sel = 3'd1;
		end else if (mreq[2]) begin
			vec = `PIU_VEC_SRC2;
			sel = 3'd2;
		end else if (mreq[3]) begin
			vec = `PIU_VEC_SRC3;
			sel = 3'd3;
		end else begin
			vec = `PIU_VEC_SRC4;
			sel = 3'd4;
		end
	end

	// Mode sequencer: one-hot, so that an illegal code falls back to normal mode.
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_NORMAL: begin
			if (take && take_nmi)
				state_d = ST_NMI;
			else if (take)
				state_d = ST_IRQ;
		end
		ST_IRQ: begin
			if (take)
				state_d = ST_NMI;
			else if (return_from_interrupt_i)
				state_d = ST_NORMAL;
		end
		ST_NMI: begin
			// A return from the non-maskable routine goes back to the mode it broke into.
			if (return_from_interrupt_i && stack_mode_irq_q)
				state_d = ST_IRQ;
			else if (return_from_interrupt_i)
				state_d = ST_NORMAL;
		end
		default: begin
			state_d = ST_NORMAL;
		end
		endcase
	end

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_NORMAL;
			mode_q <= `PIU_MODE_NORMAL;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
		end
	end

	// The port keeps the two-bit mode code, taken from the next state so that
	// it changes together with the accept pulse.
	always @* begin
		case (state_d)
		ST_IRQ: begin
			mode_d = `PIU_MODE_IRQ;
		end
		ST_NMI: begin
			mode_d = `PIU_MODE_NMI;
		end
		default: begin
			mode_d = `PIU_MODE_NORMAL;
		end
		endcase
	end

	// Software clears a polled flag by writing a one to it; a new event still wins.
	wire wr_go = avs_write_i & ~avs_waitrequest_o;
	always @* begin
		flag_clr_a = `PIU_ZERO8;
		flag_clr_b = `PIU_ZERO8;
		if (wr_go && avs_address_i == `PIU_OFS_SRCFLAG) begin
			flag_clr_a = avs_writedata_i[7:0];
			flag_clr_b = avs_writedata_i[15:8];
		end
	end

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			config_q <= `PIU_CONFIG_RST;
		else if (wr_go && avs_address_i == `PIU_OFS_CONFIG)
			config_q <= avs_writedata_i[7:0] & `PIU_CONFIG_MASK;
	end

	// Entry clears are decoded once, so that each latch sees only its own strobe.
	wire clr_nmi = take & take_nmi;
	wire clr_src1 = take & ~take_nmi & (sel == 3'h1);
	wire clr_src2 = take & ~take_nmi & (sel == 3'h2);

	// Edge wins over the entry clear so a coincident request is kept.
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nmi_q <= 1'b0;
			src1_lat_q <= 1'b0;
			src2_lat_q <= 1'b0;
		end else begin
			nmi_q <= nmi_edge | (nmi_q & ~clr_nmi);
			src1_lat_q <= (~src1_level_select & src1_edge) | (src1_lat_q & ~clr_src1);
			src2_lat_q <= src2_edge | (src2_lat_q & ~clr_src2);
		end
	end

	// The quirk keeps the core on the normal pair in interrupt mode until a return or a non-maskable entry clears it.
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_q <= 6'h00;
		end else if (flags_we_i) begin
			if (mode_q == `PIU_MODE_NMI)
				flags_q[5:4] <= {carry_i, zero_i};
			else if (mode_q == `PIU_MODE_IRQ && !quirk_q)
				flags_q[3:2] <= {carry_i, zero_i};
			else
				flags_q[1:0] <= {carry_i, zero_i};
		end
	end

	// One stack level only: a nested entry overwrites it, so the core must keep
	// its own copy of the outer return address.
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stack_q <= `PIU_ZERO12;
			stack_mode_irq_q <= 1'b0;
			quirk_q <= 1'b0;
		end else if (take) begin
			stack_q <= pc_i;
			stack_mode_irq_q <= (mode_q == `PIU_MODE_IRQ);
			quirk_q <= ~take_nmi & option_clear_window_i;
		end else if (return_from_interrupt_i && mode_q != `PIU_MODE_NORMAL) begin
			stack_mode_irq_q <= 1'b0;
			quirk_q <= 1'b0;
		end
	end

	reg [1:0] sel_flags;
	always @* begin
		sel_flags = flags_q[1:0];
		if (mode_q == `PIU_MODE_NMI)
			sel_flags = flags_q[5:4];
		else if (mode_q == `PIU_MODE_IRQ && !quirk_q)
			sel_flags = flags_q[3:2];
	end

	// Wake needs the global enable even for the non-maskable source.
	wire any_pend = nmi_q | (gen & (|mreq));
	// Acceptance outputs reach the core one cycle after the end of instruction.
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			accept_o <= 1'b0;
			vector_o <= `PIU_ZERO12;
			pc_load_o <= 1'b0;
			ret_pc_o <= `PIU_ZERO12;
			ret_o <= 1'b0;
			carry_o <= 1'b0;
			zero_o <= 1'b0;
			mode_o <= `PIU_MODE_NORMAL;
		end else begin
			accept_o <= take;
			pc_load_o <= take;
			if (take)
				vector_o <= vec;
			ret_o <= return_from_interrupt_i & (mode_q != `PIU_MODE_NORMAL);
			ret_pc_o <= stack_q;
			{carry_o, zero_o} <= sel_flags;
			mode_o <= mode_d;
		end
	end

	// Grant and wake share the pending term but answer different questions.
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_power_grant_o <= 1'b0;
			wake_o <= 1'b0;
		end else begin
			low_power_grant_o <= low_power_req_i & ~any_pend;
			wake_o <= low_power_i & gen & any_pend;
		end
	end

	// Avalon slave: one wait cycle on every access, then the answer.
	reg busy_q;
	// Busy is high only in the answer cycle, when waitrequest is already low; a request still held is taken again after it.
	wire bus_req = avs_read_i | avs_write_i;
	wire bus_take = bus_req & avs_waitrequest_o & ~busy_q;

	// Read data are decoded from the live state and registered with the answer.
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h00000000;
		case (avs_address_i)
		`PIU_OFS_STATUS: begin
			rd_mux = {28'h0000000, quirk_q, 1'b0, mode_q};
		end
		`PIU_OFS_PEND: begin
			rd_mux = {27'h0000000, mreq, nmi_q};
		end
		`PIU_OFS_SRCFLAG: begin
			rd_mux = {16'h0000, pb_flag_q, pa_flag_q};
		end
		default: begin
			rd_mux = 32'h00000000;
		end
		endcase
	end

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_q <= 1'b0;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h00000000;
		end else begin
			busy_q <= bus_take;
			avs_waitrequest_o <= ~bus_take;
			avs_readdata_o <= 32'h00000000;
			if (avs_read_i && bus_take)
				avs_readdata_o <= rd_mux;
		end
	end
endmodule

// ---- test/piu_checker.sv ----
// Port assertions for the priority interrupt unit.
`timescale 1ns/1ps
module piu_checker (
	input wire mclk_i,
	input wire rst_n_i,
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_waitrequest_o,
	input wire [31:0] avs_readdata_o,
	input wire instr_end_i,
	input wire return_from_interrupt_i,
	input wire accept_o,
	input wire pc_load_o,
	input wire [11:0] vector_o,
	input wire ret_o,
	input wire [1:0] mode_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	property p_cause; accept_o |-> $past(instr_end_i); endproperty
	a_cause: assert property (p_cause) else $error("accept cause");
	property p_load; accept_o |-> pc_load_o; endproperty
	a_load: assert property (p_load) else $error("pc load");
	property p_vec;
		accept_o |-> vector_o inside {12'hFFC, 12'hFF6, 12'hFF4, 12'hFF2, 12'hFF0};
	endproperty
	a_vec: assert property (p_vec) else $error("vector");
	property p_nmi; accept_o && vector_o == 12'hFFC |-> mode_o == 2'h2; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi mode");
	property p_nest;
		accept_o && vector_o != 12'hFFC |-> $past(mode_o) == 2'h0 && mode_o == 2'h1;
	endproperty
	a_nest: assert property (p_nest) else $error("nesting");
	property p_ack; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
	a_ack: assert property (p_ack) else $error("ack width");
	property p_cfg;
		!avs_waitrequest_o && avs_read_i && avs_address_i == 8'hC8 |-> avs_readdata_o == 32'h0;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config read");
	property p_ret; ret_o |-> $past(return_from_interrupt_i); endproperty
	a_ret: assert property (p_ret) else $error("return cause");
	c_nmi: cover property (accept_o && vector_o == 12'hFFC);
	c_ret: cover property (ret_o);
	c_rd: cover property (!avs_waitrequest_o && avs_read_i);
endmodule
bind piu_top piu_checker u_chk (.*);

// ---- test/piu_core_model.sv ----
// Core sequencer model: instruction ends, returns and program counter.
`timescale 1ns/1ps
module piu_core_model (
	input wire mclk_i,
	input wire rst_n_i,
	input wire ret_req_i,
	output reg instr_end_o,
	output reg return_o,
	output reg [11:0] pc_o
);
	reg [1:0] cyc_q;
	// Four-cycle instructions keep acceptance points sparse, as on the real core.
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cyc_q <= 2'h0;
			instr_end_o <= 1'b0;
			return_o <= 1'b0;
			pc_o <= 12'h000;
		end else begin
			cyc_q <= cyc_q + 2'h1;
			instr_end_o <= (cyc_q == 2'h3);
			return_o <= (cyc_q == 2'h3) && ret_req_i;
			if (cyc_q == 2'h3) begin
				pc_o <= pc_o + 12'h001;
			end
		end
	end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the priority interrupt unit.
`timescale 1ns/1ps
`include "piu_defs.vh"
module tb;
	reg mclk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg [7:0] addr = 8'h00;
	reg rd = 1'b0;
	reg wr = 1'b0;
	reg [31:0] wdata = 32'h0;
	reg nmi_n = 1'b1;
	reg [7:0] pa_n = 8'hFF;
	reg [7:0] pb_n = 8'hFF;
	reg timer_zero_flag = 1'b0;
	reg adc = 1'b0;
	reg ret_req = 1'b0;
	reg lp = 1'b0;
	reg owin = 1'b0;
	wire grant, wake;
	wire [31:0] rdata;
	wire waitreq, accept, ret, ie, rfi;
	wire [11:0] vec, pc;
	wire [1:0] mode;
	integer failures = 0;
	integer samples_checked = 0;
	initial forever #20 mclk_i = ~mclk_i;
	piu_core_model u_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ret_req_i(ret_req),
		.instr_end_o(ie), .return_o(rfi), .pc_o(pc));
	piu_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq), .nmi_n_i(nmi_n), .porta_irq_n_i(pa_n), .portb_irq_n_i(pb_n),
		.timer_zero_flag_i(timer_zero_flag), .timer_irq_enable_i(timer_zero_flag), .adc_eoc_i(adc), .adc_irq_enable_i(adc),
		.instr_end_i(ie), .option_clear_window_i(owin), .return_from_interrupt_i(rfi), .pc_i(pc),
		.carry_i(1'b0), .zero_i(1'b0), .flags_we_i(1'b0), .low_power_req_i(lp),
		.low_power_i(lp), .accept_o(accept), .vector_o(vec), .pc_load_o(), .ret_pc_o(),
		.ret_o(ret), .carry_o(), .zero_o(), .mode_o(mode), .low_power_grant_o(grant),
		.wake_o(wake));
	task chk(input [31:0] exp, input [31:0] got, input string nm);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("[FAIL] %0s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task results;
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task bus(input w, input [7:0] a, input [7:0] d, output [31:0] q);
		integer n;
		n = 0;
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'h000000, d};
		do begin
			@(posedge mclk_i);
			n = n + 1;
		end while (waitreq !== 1'b0 && n < 20);
		chk(32'h0, {31'h0, waitreq}, "waitrequest");
		if (waitreq !== 1'b0) results();
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge mclk_i);
	endtask
	// A zero vector means no acceptance may occur within the window.
	task acc(input [11:0] v, input [1:0] m);
		integer n;
		n = 0;
		do begin
			@(posedge mclk_i);
			n = n + 1;
		end while (accept !== 1'b1 && n < 60);
		chk({31'h0, v != 12'h000}, {31'h0, accept}, "accept");
		if (accept === 1'b1) begin
			chk({20'h00000, v}, {20'h00000, vec}, "vector");
			chk({30'h0, m}, {30'h0, mode}, "mode");
		end
	endtask
	task rti(input [1:0] m);
		integer n;
		n = 0;
		ret_req <= 1'b1;
		do begin
			@(posedge mclk_i);
			n = n + 1;
		end while (ret !== 1'b1 && n < 20);
		ret_req <= 1'b0;
		chk(32'h1, {31'h0, ret}, "return");
		@(posedge mclk_i);
		chk({30'h0, m}, {30'h0, mode}, "mode after return");
	endtask
	task s_regs;
		reg [31:0] q;
		bus(1'b1, 8'hC8, 8'h10, q);
		bus(1'b0, 8'hC8, 8'h00, q);
		chk(32'h0, q, "config read");
		bus(1'b0, 8'hE0, 8'h00, q);
		chk(32'h0, q, "unmapped read");
	endtask
	task s_nest;
		pb_n[0] <= 1'b0;
		acc(`PIU_VEC_SRC2, `PIU_MODE_IRQ);
		pa_n[0] <= 1'b0;
		timer_zero_flag <= 1'b1;
		nmi_n <= 1'b0;
		acc(`PIU_VEC_SRC0, `PIU_MODE_NMI);
		rti(`PIU_MODE_IRQ);
		rti(`PIU_MODE_NORMAL);
		acc(`PIU_VEC_SRC1, `PIU_MODE_IRQ);
		rti(`PIU_MODE_NORMAL);
		acc(`PIU_VEC_SRC3, `PIU_MODE_IRQ);
		timer_zero_flag <= 1'b0;
		rti(`PIU_MODE_NORMAL);
	endtask
	task s_gen;
		reg [31:0] q;
		bus(1'b1, 8'hC8, 8'h00, q);
		adc <= 1'b1;
		acc(12'h000, `PIU_MODE_NORMAL);
		nmi_n <= 1'b1;
		repeat (6) @(posedge mclk_i);
		nmi_n <= 1'b0;
		acc(`PIU_VEC_SRC0, `PIU_MODE_NMI);
		rti(`PIU_MODE_NORMAL);
	endtask
	task s_quirk;
		reg [31:0] q;
		owin <= 1'b1;
		bus(1'b1, 8'hC8, 8'h10, q);
		acc(`PIU_VEC_SRC4, `PIU_MODE_IRQ);
		bus(1'b0, 8'hC0, 8'h00, q);
		chk(32'h9, q, "quirk status");
		adc <= 1'b0;
		owin <= 1'b0;
		rti(`PIU_MODE_NORMAL);
		bus(1'b0, 8'hC0, 8'h00, q);
		chk(32'h0, q, "status after return");
	endtask
	task s_lp;
		reg [31:0] q;
		lp <= 1'b1;
		repeat (3) @(posedge mclk_i);
		chk(32'h1, {31'h0, grant}, "grant idle");
		chk(32'h0, {31'h0, wake}, "wake idle");
		timer_zero_flag <= 1'b1;
		repeat (3) @(posedge mclk_i);
		chk(32'h0, {31'h0, grant}, "grant pending");
		chk(32'h1, {31'h0, wake}, "wake pending");
		bus(1'b1, 8'hC8, 8'h00, q);
		repeat (3) @(posedge mclk_i);
		chk(32'h0, {31'h0, wake}, "wake gen off");
		chk(32'h1, {31'h0, grant}, "grant gen off");
		timer_zero_flag <= 1'b0;
		lp <= 1'b0;
		rti(`PIU_MODE_NORMAL);
	endtask
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		s_regs();
		s_nest();
		s_gen();
		s_quirk();
		s_lp();
		results();
	end
endmodule
